// ==== eprom_device_model.sv ====
// Behavioural model of the byte-wide EPROM seen on the programmer's pins.
// Assumes the package's pin bundle; pulse widths are taken from sim time.
`timescale 1ns/10ps
module eprom_device_model
  import eprom_prog_pkg::*;
#(
  parameter logic [6:0] MFR_CODE = 7'h2A,  // Arbitrary value
  parameter logic [6:0] PROD_CODE = 7'h35  // Arbitrary value
) (
  // Pins
  input wire eprom_prog_pkg::pins_t PINS,
  output logic [7:0] DEV_DIN,
  // Test control
  input wire logic ERASE,
  input wire logic [4:0] NEED
);
  // ****************
  // Cells and trackers
  // ****************
  logic [7:0] mem [0:(1<<ADDR_W)-1];
  logic [4:0] pulses [0:(1<<ADDR_W)-1];
  logic [7:0] drv, pdata;
  logic [7:0] last = 8'h00;
  logic [ADDR_W-1:0] paddr;
  logic verified = 1'b0;
  logic in_pulse = 1'b0;
  realtime t0, w;
  int errs = 0;
  int final_reads = 0;

  // Erase returns every cell to ones
  always @(posedge ERASE) begin
    for (int a = 0; a < (1 << ADDR_W); a++) begin
      mem[a] = ERASED_BYTE;
      pulses[a] = 5'h00;
    end
    final_reads = 0;
  end

  // Data outputs; a released bus shows the inverse of the last byte
  always @* begin
    if (PINS.chip_select_n || PINS.output_gate_n) drv = ~last;
    else if (PINS.id_hv_en) drv = PINS.addr[ID_SEL_BIT] ?
      {~^PROD_CODE, PROD_CODE} : {~^MFR_CODE, MFR_CODE};
    else drv = mem[PINS.addr];
  end

  // Remember the last byte really driven
  always @(drv) begin
    if (!PINS.chip_select_n && !PINS.output_gate_n) last = drv;
  end
  assign #100 DEV_DIN = drv;

  // Reads: id entry, contention, verify and final pass
  always @(negedge PINS.output_gate_n) begin
    if (!PINS.chip_select_n && PINS.dout_oe) errs++;
    if (PINS.id_hv_en && (PINS.vpp_en || PINS.chip_select_n ||
        (PINS.addr & ~((14'h1 << ID_SEL_BIT) | (14'h1 << ID_HV_BIT))) != 14'h0)) errs++;
    if (!PINS.chip_select_n && PINS.vpp_en) verified = 1'b1;
    if (!PINS.chip_select_n && !PINS.vpp_en && !PINS.vcc_prog_lvl && !PINS.id_hv_en)
      final_reads++;
  end

  // Strobe low opens a pulse and captures address and byte
  always @(negedge PINS.program_strobe_n) begin
    t0 = $realtime;
    in_pulse = 1'b1;
    paddr = PINS.addr;
    pdata = PINS.dout;
    if (!PINS.vpp_en || !PINS.vcc_en || PINS.chip_select_n || !PINS.output_gate_n ||
        !PINS.dout_oe) errs++;
    if (pulses[paddr] != 5'h00 && !verified) errs++;
    verified = 1'b0;
  end

  // Strobe high closes a pulse, classed by its width
  always @(posedge PINS.program_strobe_n) begin
    w = $realtime - t0;
    if (!in_pulse) w = 0;
    else if (w >= 950000 && w <= 1050000) begin
      pulses[paddr]++;
      if (pulses[paddr] > MAX_PULSES) errs++;
      if (pulses[paddr] >= NEED) mem[paddr] = mem[paddr] & pdata;
    end else if (pulses[paddr] != 5'h00) begin
      if (w < 3.8e6 || w > 63.0e6 || w < 0.95e6 * OVER_FACTOR * pulses[paddr] ||
          w > 1.05e6 * OVER_FACTOR * pulses[paddr] || mem[paddr] !== pdata) errs++;
    end else if (w >= 45.0e6 && w <= 55.0e6) mem[paddr] = mem[paddr] & pdata;
    else errs++;
    in_pulse = 1'b0;
  end

  // Logic supply must stand whenever programming supply is on
  always @(PINS.vpp_en or PINS.vcc_en) begin
    if (PINS.vpp_en && !PINS.vcc_en) errs++;
  end
endmodule

// ==== eprom_prog_pkg.sv ====
// Package for the EPROM programmer controller: timing counts, pin struct and result codes.
// Assumes a 40 MHz single clock; supplies are switched by external drivers from enables.
package eprom_prog_pkg;

  // ****************************************************
  // Clock and timing
  // ****************************************************
  localparam int CLK_HZ = 40000000;
  localparam int PULSE_US = 1000;          // Nominal fast program pulse, 1 ms
  localparam int LONG_PULSE_US = 50000;    // Conventional pulse, 50 ms
  localparam int SETUP_US = 2;             // Address, data, supply, strobe setup
  localparam int ACCESS_NS = 450;          // Slowest read access allowed
  localparam int OVER_FACTOR = 4;          // Overprogram length per fast pulse
  localparam int MAX_PULSES = 15;          // Fast pulse limit per byte
  localparam int US_CYC = (CLK_HZ + 999999) / 1000000;
  localparam int PULSE_CYC = PULSE_US * US_CYC;
  localparam int LONG_CYC = LONG_PULSE_US * US_CYC;
  localparam int SETUP_CYC = SETUP_US * US_CYC;
  localparam int ACCESS_CYC = (ACCESS_NS * (CLK_HZ / 1000000) + 999) / 1000;

  // ****************************************************
  // Widths and field positions
  // ****************************************************
  localparam int ADDR_W = 14;
  localparam int ID_SEL_BIT = 0;
  localparam int ID_HV_BIT = 9;
  localparam int PARITY_BIT = 7;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [3:0] MAX_PULSES_4 = 4'hF;

  // ****************************************************
  // Pin bundle and result codes
  // ****************************************************
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] dout;
    logic dout_oe;
    logic chip_select_n;
    logic output_gate_n;
    logic program_strobe_n;
    logic id_hv_en;      // Elevated voltage on the id address line
    logic vcc_en;
    logic vcc_prog_lvl;  // Logic supply at programming level
    logic vpp_en;        // Programming supply at high level
  } pins_t;

  typedef enum logic [2:0] {
    RES_NONE = 3'h0,
    RES_OK = 3'h1,
    RES_ID_BAD = 3'h2,
    RES_PROG_FAIL = 3'h3,
    RES_VERIFY_FAIL = 3'h4
  } result_t;

endpackage

// ==== eprom_programmer.sv ====
// Programmer controller: identifies, programs and verifies a byte-wide EPROM.
// Assumes external level shifters from the enable outputs and an image source
// that returns the byte for the address on IMG_ADDR in the same cycle.
`timescale 1ns/10ps

// Overview of operation
// RQ1 - Id mode: high voltage on id line, select and gate low, other address low.
// RQ2 - Device gives two id bytes chosen by lowest address bit.
// RQ3 - Id bytes carry code in bits 0-6, bit 7 odd parity.
// RQ4 - Compare both id bytes with expected values; program only on match.
// RQ5 - Fast mode applies 1 ms strobe pulses to each byte.
// RQ6 - After every 1 ms pulse the byte is read back and compared.
// RQ7 - Once correct, one overprogram pulse of four times pulse count.
// RQ8 - Count 1 ms pulses per byte, never more than fifteen.
// RQ9 - Overprogram length 4 to 60 ms, from the pulse counter.
// RQ10 - After programming read every byte back at normal supply levels.
// RQ11 - Logic supply on before and off after programming supply.
// RQ12 - Optional conventional mode: one 50 ms pulse, no overprogram.
// RQ13 - Device floats outputs when gate or select goes high; the device model drives the inverse of the last byte instead.
// RQ14 - Erased bytes read all ones; skip bytes equal to erased value.
// RQ15 - Program: supply high, strobe low, select low, gate high.
// RQ16 - Byte failing after fifteen pulses stops with a failure result.
module eprom_programmer (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic ARST_N,
  // Job control
  input wire logic START,
  input wire logic LONG_MODE,
  input wire logic [7:0] EXP_MFR,
  input wire logic [7:0] EXP_PROD,
  input wire logic [eprom_prog_pkg::ADDR_W-1:0] LAST_ADDR,
  // Image source
  output logic [eprom_prog_pkg::ADDR_W-1:0] IMG_ADDR,
  input wire logic [7:0] IMG_DATA,
  // Device pins
  output eprom_prog_pkg::pins_t PINS,
  input wire logic [7:0] DEV_DIN,
  // Status
  output logic BUSY,
  output eprom_prog_pkg::result_t RESULT,
  output logic [eprom_prog_pkg::ADDR_W-1:0] FAIL_ADDR
);
  import eprom_prog_pkg::*;

  typedef enum logic [4:0] {
    S_IDLE = 5'h00,
    S_VCC_ON = 5'h01,
    S_ID_SET = 5'h02,
    S_ID_READ = 5'h03,
    S_VPP_ON = 5'h04,
    S_FETCH = 5'h05,
    S_PGM_SETUP = 5'h06,
    S_PGM_PULSE = 5'h07,
    S_PGM_HOLD = 5'h08,
    S_VER_SETUP = 5'h09,
    S_VER_READ = 5'h0A,
    S_OVER_SETUP = 5'h0B,
    S_OVER_PULSE = 5'h0C,
    S_NEXT = 5'h0D,
    S_VPP_OFF = 5'h0E,
    S_FIN_SETUP = 5'h0F,
    S_FIN_READ = 5'h10,
    S_VCC_OFF = 5'h11
  } st_t;

  typedef struct packed {
    st_t st;
    pins_t pins;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
    logic [3:0] npulse;
    logic [5:0] over_cnt;
    logic id_byte;
    logic busy;
    result_t result;
    logic [ADDR_W-1:0] fail_addr;
    logic long_mode;
    logic tstart;
    logic [23:0] tcyc;
  } state_t;

  state_t s_q, s_d;
  logic [7:0] din_m, din_s;
  logic tdone;

  // Odd parity check of a byte read from the id row
  function automatic logic odd_ok(input logic [7:0] b);
    odd_ok = ^b;
  endfunction

  // Cycle count for a timed wait, cut to the timer's 24 bits
  function automatic logic [23:0] cyc24(input int n);
    cyc24 = n[23:0];
  endfunction

  // ****************************************************
  // Pin input synchroniser
  // ****************************************************
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      din_m <= 8'h00;
      din_s <= 8'h00;
    end else begin
      din_m <= DEV_DIN;
      din_s <= din_m;
    end
  end

  // ****************************************************
  // Sequencer
  // ****************************************************
  always_comb begin
    s_d = s_q;
    s_d.tstart = 1'b0;
    unique case (s_q.st)
      S_IDLE: begin
        if (START) begin
          s_d.busy = 1'b1;
          s_d.result = RES_NONE;
          s_d.long_mode = LONG_MODE;
          s_d.pins.vcc_en = 1'b1; // RQ11
          s_d.st = S_VCC_ON;
          s_d.tstart = 1'b1;
          s_d.tcyc = cyc24(SETUP_CYC);
        end
      end
      S_VCC_ON: begin
        if (tdone) begin
          // Id entry: every address low except select bit
          s_d.pins.addr = '0; // RQ1
          s_d.pins.id_hv_en = 1'b1; // RQ1
          s_d.pins.chip_select_n = 1'b0; // RQ1
          s_d.pins.output_gate_n = 1'b0; // RQ1
          s_d.id_byte = 1'b0;
          s_d.st = S_ID_SET;
          s_d.tstart = 1'b1;
          s_d.tcyc = cyc24(SETUP_CYC);
        end
      end
      S_ID_SET: begin
        if (tdone) begin
          s_d.st = S_ID_READ;
          s_d.tstart = 1'b1;
          s_d.tcyc = cyc24(ACCESS_CYC + 2);
        end
      end
      S_ID_READ: begin
        if (tdone) begin
          // Mismatch or bad parity aborts before any programming
          if (din_s != (s_q.id_byte ? EXP_PROD : EXP_MFR) || !odd_ok(din_s)) begin // RQ4
            s_d.result = RES_ID_BAD;
            s_d.pins.id_hv_en = 1'b0;
            s_d.pins.output_gate_n = 1'b1;
            s_d.st = S_VCC_OFF;
          end else if (!s_q.id_byte) begin
            s_d.id_byte = 1'b1;
            s_d.pins.addr[ID_SEL_BIT] = 1'b1; // RQ2
            s_d.st = S_ID_SET;
          end else begin
            s_d.pins.id_hv_en = 1'b0;
            s_d.pins.output_gate_n = 1'b1;
            s_d.pins.chip_select_n = 1'b1;
            s_d.pins.vcc_prog_lvl = ~s_q.long_mode;
            s_d.pins.vpp_en = 1'b1; // RQ11
            s_d.addr = '0;
            s_d.st = S_VPP_ON;
          end
          s_d.tstart = 1'b1;
          s_d.tcyc = cyc24(SETUP_CYC);
        end
      end
      S_VPP_ON: begin
        if (tdone) begin
          s_d.st = S_FETCH;
        end
      end
      S_FETCH: begin
        // Image byte for s_q.addr arrives this cycle
        s_d.data = IMG_DATA;
        s_d.npulse = 4'h0;
        if (IMG_DATA == ERASED_BYTE) begin // RQ14
          s_d.st = S_NEXT;
        end else begin
          s_d.pins.addr = s_q.addr;
          s_d.pins.dout = IMG_DATA;
          s_d.pins.dout_oe = 1'b1;
          s_d.pins.chip_select_n = 1'b0; // RQ15
          s_d.pins.output_gate_n = 1'b1; // RQ15
          s_d.st = S_PGM_SETUP;
          s_d.tstart = 1'b1;
          s_d.tcyc = cyc24(SETUP_CYC);
        end
      end
      S_PGM_SETUP: begin
        if (tdone) begin
          s_d.pins.program_strobe_n = 1'b0; // RQ15
          s_d.npulse = s_q.npulse + 4'h1; // RQ8
          s_d.st = S_PGM_PULSE;
          s_d.tstart = 1'b1;
          s_d.tcyc = s_q.long_mode ? cyc24(LONG_CYC) : cyc24(PULSE_CYC); // RQ5 RQ12
        end
      end
      S_PGM_PULSE: begin
        if (tdone) begin
          s_d.pins.program_strobe_n = 1'b1;
          s_d.st = S_PGM_HOLD;
          s_d.tstart = 1'b1;
          s_d.tcyc = cyc24(SETUP_CYC);
        end
      end
      S_PGM_HOLD: begin
        if (tdone) begin
          if (s_q.long_mode) begin
            s_d.pins.dout_oe = 1'b0;
            s_d.st = S_NEXT; // RQ12
          end else begin
            s_d.pins.dout_oe = 1'b0;
            s_d.pins.output_gate_n = 1'b0; // RQ6
            s_d.st = S_VER_SETUP;
            s_d.tstart = 1'b1;
            s_d.tcyc = cyc24(ACCESS_CYC + 2);
          end
        end
      end
      S_VER_SETUP: begin
        if (tdone) begin
          s_d.st = S_VER_READ;
        end
      end
      S_VER_READ: begin
        s_d.pins.output_gate_n = 1'b1;
        s_d.tstart = 1'b1;
        s_d.tcyc = cyc24(SETUP_CYC);
        s_d.pins.dout_oe = 1'b1;
        if (din_s == s_q.data) begin // RQ6
          s_d.over_cnt = {s_q.npulse, 2'b00}; // RQ7 RQ9
          s_d.st = S_OVER_SETUP;
        end else if (s_q.npulse == MAX_PULSES_4) begin // RQ8
          s_d.result = RES_PROG_FAIL; // RQ16
          s_d.fail_addr = s_q.addr;
          s_d.pins.dout_oe = 1'b0;
          s_d.pins.chip_select_n = 1'b1;
          s_d.st = S_VPP_OFF;
        end else begin
          s_d.st = S_PGM_SETUP;
        end
      end
      S_OVER_SETUP: begin
        if (tdone) begin
          s_d.pins.program_strobe_n = 1'b0; // RQ7
          s_d.st = S_OVER_PULSE;
          s_d.tstart = 1'b1;
          s_d.tcyc = cyc24(PULSE_CYC);
        end
      end
      S_OVER_PULSE: begin
        // Overprogram runs as over_cnt back-to-back 1 ms chunks
        if (tdone) begin
          if (s_q.over_cnt == 6'h01) begin
            s_d.pins.program_strobe_n = 1'b1;
            s_d.pins.dout_oe = 1'b0;
            s_d.st = S_NEXT;
          end else begin
            s_d.over_cnt = s_q.over_cnt - 6'h01; // RQ9
            s_d.tstart = 1'b1;
            s_d.tcyc = cyc24(PULSE_CYC);
          end
        end
      end
      S_NEXT: begin
        if (!s_q.tstart && (s_q.pins.program_strobe_n)) begin
          if (s_q.addr == LAST_ADDR) begin
            s_d.pins.chip_select_n = 1'b1;
            s_d.pins.vpp_en = 1'b0; // RQ11
            s_d.st = S_VPP_OFF;
            s_d.tstart = 1'b1;
            s_d.tcyc = cyc24(SETUP_CYC);
          end else begin
            s_d.addr = s_q.addr + {{(ADDR_W-1){1'b0}}, 1'b1};
            s_d.st = S_FETCH;
          end
        end
      end
      S_VPP_OFF: begin
        s_d.pins.vpp_en = 1'b0;
        s_d.pins.vcc_prog_lvl = 1'b0; // RQ10
        if (tdone) begin
          if (s_q.result == RES_PROG_FAIL) begin
            s_d.st = S_VCC_OFF;
          end else begin
            s_d.addr = '0;
            s_d.st = S_FIN_SETUP;
          end
          s_d.tstart = 1'b1;
          s_d.tcyc = cyc24(SETUP_CYC);
        end
      end
      S_FIN_SETUP: begin
        s_d.pins.addr = s_q.addr;
        s_d.pins.chip_select_n = 1'b0;
        s_d.pins.output_gate_n = 1'b0;
        s_d.data = IMG_DATA;
        if (tdone) begin
          s_d.st = S_FIN_READ;
        end
      end
      S_FIN_READ: begin
        // Normal-level read of every byte
        if (din_s != s_q.data) begin // RQ10
          s_d.result = RES_VERIFY_FAIL;
          s_d.fail_addr = s_q.addr;
          s_d.st = S_VCC_OFF;
        end else if (s_q.addr == LAST_ADDR) begin
          s_d.result = RES_OK;
          s_d.st = S_VCC_OFF;
        end else begin
          s_d.addr = s_q.addr + {{(ADDR_W-1){1'b0}}, 1'b1};
          s_d.st = S_FIN_SETUP;
        end
        // Gate rises after every byte so each address is a separate read
        s_d.pins.output_gate_n = 1'b1; // RQ10
        s_d.tstart = 1'b1;
        s_d.tcyc = cyc24(ACCESS_CYC + 2);
      end
      S_VCC_OFF: begin
        s_d.pins.vpp_en = 1'b0;
        s_d.pins.chip_select_n = 1'b1;
        s_d.pins.output_gate_n = 1'b1;
        if (tdone) begin
          s_d.pins.vcc_en = 1'b0; // RQ11
          s_d.busy = 1'b0;
          s_d.st = S_IDLE;
        end
      end
      default: begin
        s_d.st = S_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s_q <= '0;
      s_q.pins.chip_select_n <= 1'b1;
      s_q.pins.output_gate_n <= 1'b1;
      s_q.pins.program_strobe_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************
  // Interval timer
  // ****************************************************
  eprom_timer u_timer (
    .clk(REF_CLK),
    .arst_n(ARST_N),
    .start(s_q.tstart),
    .cycles(s_q.tcyc),
    .done(tdone)
  );

  // Outputs
  assign PINS = s_q.pins;
  assign IMG_ADDR = s_q.addr;
  assign BUSY = s_q.busy;
  assign RESULT = s_q.result;
  assign FAIL_ADDR = s_q.fail_addr;

  // ****************************************************
  // Checks
  // ****************************************************
  a_vpp_after_vcc: assert property (@(posedge REF_CLK) disable iff (!ARST_N) // RQ11
    s_q.pins.vpp_en |-> s_q.pins.vcc_en) else $error("vpp on without vcc");
  a_strobe_cond: assert property (@(posedge REF_CLK) disable iff (!ARST_N) // RQ15
    !s_q.pins.program_strobe_n |-> s_q.pins.vpp_en && !s_q.pins.chip_select_n
    && s_q.pins.output_gate_n) else $error("strobe without program setup");
  a_pulse_limit: assert property (@(posedge REF_CLK) disable iff (!ARST_N) // RQ8
    s_q.npulse <= MAX_PULSES_4) else $error("too many pulses");
  a_id_entry: assert property (@(posedge REF_CLK) disable iff (!ARST_N) // RQ1
    s_q.pins.id_hv_en |-> s_q.pins.addr[ADDR_W-1:1] == '0) else $error("id address bad");
  a_over_len: assert property (@(posedge REF_CLK) disable iff (!ARST_N) // RQ7
    $rose(s_q.st == S_OVER_SETUP) |-> s_q.over_cnt == {s_q.npulse, 2'b00})
    else $error("overprogram length wrong");
  a_fail_stop: assert property (@(posedge REF_CLK) disable iff (!ARST_N) // RQ16
    s_q.result == RES_PROG_FAIL |-> s_q.st != S_OVER_PULSE) else $error("overprogram after fail");
  a_strobe_end: assert property (@(posedge REF_CLK) disable iff (!ARST_N) // RQ5
    $fell(s_q.pins.program_strobe_n) && !s_q.long_mode && s_q.st == S_PGM_PULSE
    |-> ##1 !s_q.pins.program_strobe_n) else $error("strobe too short");
  a_final_lvl: assert property (@(posedge REF_CLK) disable iff (!ARST_N) // RQ10
    s_q.st == S_FIN_READ |-> !s_q.pins.vpp_en && !s_q.pins.vcc_prog_lvl)
    else $error("final read at program levels");
endmodule

// ==== eprom_programmer_tb.sv ====
// Testbench for the EPROM programmer against the behavioural device model.
// Assumes the model file; full-length pulses make the run a few million cycles.
`timescale 1ns/10ps
module eprom_programmer_tb;
  import eprom_prog_pkg::*;
  localparam logic [6:0] MFR_CODE = 7'h2A;  // Arbitrary value
  localparam logic [6:0] PROD_CODE = 7'h35; // Arbitrary value
  localparam int LIMIT = 4000000;

`define CHECK(what, exp, got) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      $display("unexpected %s: expected %0h seen %0h", what, exp, got); \
      n_errors++; \
    end \
  end

  logic ref_clk, arst_n, start, long_mode, busy, erase;
  logic [7:0] exp_mfr, exp_prod, img_data, dev_din;
  logic [ADDR_W-1:0] last_addr, img_addr, fail_addr;
  logic [4:0] need;
  logic [7:0] img [0:3];
  pins_t pins;
  result_t result;
  int n_errors = 0;
  int n_compared = 0;
  int seed = 61;
  int cycles = 0;

  assign img_data = img[img_addr[1:0]];

  eprom_programmer eprom_programmer_i (
    .REF_CLK(ref_clk), .ARST_N(arst_n), .START(start), .LONG_MODE(long_mode),
    .EXP_MFR(exp_mfr), .EXP_PROD(exp_prod), .LAST_ADDR(last_addr),
    .IMG_ADDR(img_addr), .IMG_DATA(img_data), .PINS(pins), .DEV_DIN(dev_din),
    .BUSY(busy), .RESULT(result), .FAIL_ADDR(fail_addr)
  );

  eprom_device_model #(.MFR_CODE(MFR_CODE), .PROD_CODE(PROD_CODE)) eprom_device_model_i (
    .PINS(pins), .DEV_DIN(dev_din), .ERASE(erase), .NEED(need)
  );

  // ****************
  // Helpers
  // ****************
  // Id byte with odd parity on top
  function automatic logic [7:0] id_byte(input logic [6:0] c);
    return {~^c, c};
  endfunction

  // Fast pulses a byte should receive
  function automatic logic [4:0] exp_pulses(input logic [7:0] b, input logic [4:0] n);
    return (b == ERASED_BYTE) ? 5'h00 : ((n > MAX_PULSES) ? 5'(MAX_PULSES) : n);
  endfunction

  // Verdict and end of run
  task automatic end_sim();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // One job; optionally a stray start mid-job
  task automatic run_job(input logic lm, input logic [ADDR_W-1:0] la, input logic poke);
    int k;
    k = 0;
    @(posedge ref_clk);
    #2;
    long_mode = lm;
    last_addr = la;
    start = 1'b1;
    @(posedge ref_clk);
    #2;
    start = 1'b0;
    `CHECK("busy", 1'b1, busy)
    while (busy === 1'b1) begin
      @(posedge ref_clk);
      #2;
      start = poke && (k == 50);
      k++;
    end
  endtask

  // Fresh device and new image
  task automatic new_part(input logic [4:0] n);
    erase = 1'b0;
    #1 erase = 1'b1;
    need = n;
    img[0] = 8'($random(seed)) & 8'h7E;
    img[1] = ERASED_BYTE;
    img[2] = 8'($random(seed));
    img[3] = 8'h00;
  endtask

  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_errors++;
      end_sim();
    end
  end

  // ****************
  // Main sequence
  // ****************
  initial begin
    arst_n = 1'b0;
    start = 1'b0;
    long_mode = 1'b0;
    last_addr = '0;
    erase = 1'b0;
    exp_mfr = id_byte(MFR_CODE);
    exp_prod = id_byte(PROD_CODE);
    new_part(5'h02);
    repeat (5) @(posedge ref_clk);
    `CHECK("reset strobe", 1'b1, pins.program_strobe_n)
    `CHECK("reset select", 1'b1, pins.chip_select_n)
    `CHECK("reset vpp", 1'b0, pins.vpp_en)
    `CHECK("reset result", RES_NONE, result)
    #2 arst_n = 1'b1;
    // Wrong maker code, then even parity on product code
    for (int i = 0; i < 2; i++) begin
      exp_mfr = id_byte(MFR_CODE) ^ ((i == 0) ? (8'($random(seed)) | 8'h01) : 8'h00);
      exp_prod = id_byte(PROD_CODE) ^ ((i == 1) ? 8'h80 : 8'h00);
      run_job(1'b0, 14'h0002, 1'b0);
      `CHECK("id result", RES_ID_BAD, result)
      `CHECK("id no pulse", 5'h00, eprom_device_model_i.pulses[0])
    end
    exp_mfr = id_byte(MFR_CODE);
    exp_prod = id_byte(PROD_CODE);
    // Fast program with an erased byte in the middle and a stray start
    run_job(1'b0, 14'h0002, 1'b1);
    `CHECK("fast result", RES_OK, result)
    for (int a = 0; a < 3; a++) begin
      `CHECK("fast byte", img[a], eprom_device_model_i.mem[a])
      `CHECK("fast pulses", exp_pulses(img[a], need), eprom_device_model_i.pulses[a])
    end
    `CHECK("final reads", 1'b1, eprom_device_model_i.final_reads >= 3)
    // Byte that never takes: stop after the limit
    new_part(5'h10);
    run_job(1'b0, 14'h0000, 1'b0);
    `CHECK("fail result", RES_PROG_FAIL, result)
    `CHECK("fail addr", 14'h0000, fail_addr)
    `CHECK("fail pulses", exp_pulses(img[0], need), eprom_device_model_i.pulses[0])
    // Conventional single long pulse
    new_part(5'h01);
    run_job(1'b1, 14'h0000, 1'b0);
    `CHECK("long result", RES_OK, result)
    `CHECK("long byte", img[0], eprom_device_model_i.mem[0])
    `CHECK("long pulses", 5'h00, eprom_device_model_i.pulses[0])
    `CHECK("pin misuse", 0, eprom_device_model_i.errs)
    end_sim();
  end
endmodule

// ==== eprom_timer.sv ====
// Down counter giving a done pulse after a loaded number of cycles.
// Assumes the loader holds start for one cycle only.
`timescale 1ns/10ps
module eprom_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Control
  input wire logic start,
  input wire logic [23:0] cycles,
  output logic done
);
  import eprom_prog_pkg::*;

  typedef struct packed {
    logic [23:0] cnt;
    logic run;
    logic done;
  } tstate_t;

  tstate_t s_q, s_d;

  // Count down, one-cycle done when the count reaches one
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (start) begin
      s_d.cnt = cycles;
      s_d.run = 1'b1;
    end else if (s_q.run) begin
      if (s_q.cnt <= 24'h000001) begin
        s_d.run = 1'b0;
        s_d.done = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt - 24'h000001;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done = s_q.done;
endmodule
